/* shared/slrxc_pkg.sv */
// package for the serial link receive configuration register slice
// assumes a 32-bit avalon-mm slave with word addressing by index * 4
package slrxc_pkg;
	// register indices; byte address is index * 4
	localparam logic [9:0] SLRXC_IDX_TRIM5 = 10'h2c0;
	localparam logic [9:0] SLRXC_IDX_TRIM6 = 10'h2c1;
	localparam logic [9:0] SLRXC_IDX_TRIM7 = 10'h2c2;
	localparam logic [9:0] SLRXC_IDX_CTRL = 10'h300;
	localparam logic [9:0] SLRXC_IDX_LAT = 10'h302;
	localparam logic [9:0] SLRXC_IDX_FIXDLY = 10'h304;
	localparam logic [9:0] SLRXC_IDX_REL = 10'h306;
	localparam logic [9:0] SLRXC_IDX_XBAR01 = 10'h308;
	// field positions
	localparam int SLRXC_CKSUM_BIT = 6;
	localparam int SLRXC_LINK_EN_BIT = 0;
	localparam int SLRXC_LANE1_LSB = 3;
	localparam int SLRXC_TRIM_SIGN = 3;
	// reset values
	localparam logic [3:0] SLRXC_TRIM_RST = 4'h0;
	localparam logic [4:0] SLRXC_FIXDLY_RST = 5'h00;
	localparam logic [4:0] SLRXC_REL_RST = 5'h1f;
	localparam logic [2:0] SLRXC_LANE1_RST = 3'h1;
	localparam logic [2:0] SLRXC_LANE0_RST = 3'h0;
	localparam logic [2:0] SLRXC_TERM_RST = 3'h0;
	localparam logic SLRXC_CKSUM_RST = 1'h0;
	localparam logic SLRXC_LINK_EN_RST = 1'h0;
	// software upper bound on release position
	localparam logic [4:0] SLRXC_REL_MAX = 5'h0a;
	// bus states
	typedef enum logic [1:0] {
		SLRXC_IDLE = 2'b00,
		SLRXC_ACK = 2'b01
	} slrxc_bus_t;
endpackage

/* logic/slrxc_regs.sv */
// register slice for the serial link receiver configuration and status
// assumes an avalon-mm master on clk_sys and lane calibration from outside
//
// Operation
// (R1) trim field: four-bit sign-magnitude, bit 3 subtracts, bits 2:0 magnitude.
// (R2) lanes 5, 6, 7 each adjust calibrated termination by own trim.
// (R3) checksum mode bit: zero sums fields, one sums octets.
// (R4) link enable set after setup brings receive link out of idle.
// (R5) read-only five-bit measured latency in processing-clock units.
// (R6) five-bit writable fixed multiframe delay for link 0.
// (R7) five-bit writable buffer release position, variable delay part.
// (R8) software keeps release position at or below ten.
// (R9) three-bit source select for logical lane 1, reset to input 1.
// (R10) crossbar code is the binary index of the physical input.
// (R11) reserved bits read zero and ignore writes.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module slrxc_regs
	import slrxc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// termination calibration inputs and adjusted outputs
	input wire logic [2:0] cal_term_lane5,
	input wire logic [2:0] cal_term_lane6,
	input wire logic [2:0] cal_term_lane7,
	output logic [2:0] term_lane5,
	output logic [2:0] term_lane6,
	output logic [2:0] term_lane7,
	// receiver interface
	input wire logic [4:0] measured_latency,
	output logic link_enable,
	output logic checksum_octets,
	output logic [4:0] fixed_multiframe_delay,
	output logic [4:0] buffer_release_position,
	output logic [2:0] logical_lane0_source,
	output logic [2:0] logical_lane1_source
);
	////////////////////////////////////////////////////////////////////////////
	// reset synchroniser
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [3:0] trim5_q, trim5_d, trim6_q, trim6_d, trim7_q, trim7_d;
	logic cksum_q, cksum_d, link_en_q, link_en_d;
	logic [4:0] fixdly_q, fixdly_d, rel_q, rel_d;
	logic [2:0] lane0_q, lane0_d, lane1_q, lane1_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] resp_q, resp_d;
	slrxc_bus_t st_q, st_d;
	logic [9:0] idx;
	logic hit, wr_lo;
	logic [7:0] rd_byte;

	assign idx = avs_address[11:2];
	assign wr_lo = avs_write && avs_byteenable[0];

	// read decode; unused bits stay zero
	always_comb begin
		hit = 1'b1;
		rd_byte = 8'h00;
		unique case (idx)
			SLRXC_IDX_TRIM5: rd_byte = {4'h0, trim5_q}; // [R11]
			SLRXC_IDX_TRIM6: rd_byte = {4'h0, trim6_q};
			SLRXC_IDX_TRIM7: rd_byte = {4'h0, trim7_q};
			SLRXC_IDX_CTRL: rd_byte = {1'b0, cksum_q, 5'h00, link_en_q}; // [R11]
			SLRXC_IDX_LAT: rd_byte = {3'h0, measured_latency}; // [R5]
			SLRXC_IDX_FIXDLY: rd_byte = {3'h0, fixdly_q};
			SLRXC_IDX_REL: rd_byte = {3'h0, rel_q};
			SLRXC_IDX_XBAR01: rd_byte = {2'h0, lane1_q, lane0_q};
			default: hit = 1'b0;
		endcase
	end

	// next values: one-wait-state bus and field writes
	always_comb begin
		st_d = st_q;
		rdata_d = rdata_q;
		resp_d = resp_q;
		trim5_d = trim5_q;
		trim6_d = trim6_q;
		trim7_d = trim7_q;
		cksum_d = cksum_q;
		link_en_d = link_en_q;
		fixdly_d = fixdly_q;
		rel_d = rel_q;
		lane0_d = lane0_q;
		lane1_d = lane1_q;
		unique case (st_q)
			SLRXC_IDLE: begin
				if (avs_read || avs_write) begin
					st_d = SLRXC_ACK;
					rdata_d = avs_read ? {24'h000000, rd_byte} : 32'h00000000;
					resp_d = hit ? 2'b00 : 2'b11; // decode error if unmapped
					if (wr_lo && hit) begin
						unique case (idx)
							SLRXC_IDX_TRIM5: trim5_d = avs_writedata[3:0]; // [R1] [R2]
							SLRXC_IDX_TRIM6: trim6_d = avs_writedata[3:0]; // [R2]
							SLRXC_IDX_TRIM7: trim7_d = avs_writedata[3:0]; // [R2]
							SLRXC_IDX_CTRL: begin
								cksum_d = avs_writedata[SLRXC_CKSUM_BIT]; // [R3]
								link_en_d = avs_writedata[SLRXC_LINK_EN_BIT]; // [R4]
							end
							SLRXC_IDX_FIXDLY: fixdly_d = avs_writedata[4:0]; // [R6]
							SLRXC_IDX_REL: rel_d = avs_writedata[4:0]; // [R7] not clipped
							SLRXC_IDX_XBAR01: begin
								lane0_d = avs_writedata[2:0];
								lane1_d = avs_writedata[SLRXC_LANE1_LSB +: 3]; // [R9]
							end
							default: ;
						endcase
					end
				end
			end
			SLRXC_ACK: st_d = SLRXC_IDLE;
			default: st_d = SLRXC_IDLE;
		endcase
	end

	// register everything
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= SLRXC_IDLE;
			rdata_q <= 32'h00000000;
			resp_q <= 2'b00;
			trim5_q <= SLRXC_TRIM_RST;
			trim6_q <= SLRXC_TRIM_RST;
			trim7_q <= SLRXC_TRIM_RST;
			cksum_q <= SLRXC_CKSUM_RST;
			link_en_q <= SLRXC_LINK_EN_RST;
			fixdly_q <= SLRXC_FIXDLY_RST;
			rel_q <= SLRXC_REL_RST;
			lane0_q <= SLRXC_LANE0_RST;
			lane1_q <= SLRXC_LANE1_RST; // [R9]
		end else begin
			st_q <= st_d;
			rdata_q <= rdata_d;
			resp_q <= resp_d;
			trim5_q <= trim5_d;
			trim6_q <= trim6_d;
			trim7_q <= trim7_d;
			cksum_q <= cksum_d;
			link_en_q <= link_en_d;
			fixdly_q <= fixdly_d;
			rel_q <= rel_d;
			lane0_q <= lane0_d;
			lane1_q <= lane1_d;
		end
	end

	// bus answer: waitrequest drops in the cycle after the request is seen
	assign avs_waitrequest = (st_q != SLRXC_ACK);
	assign avs_readdata = rdata_q;
	assign avs_response = resp_q;

	////////////////////////////////////////////////////////////////////////////
	// termination trim: sign-magnitude add, saturate to 0..7
	function automatic logic [2:0] slrxc_trim(input logic [2:0] cal, input logic [3:0] t);
		logic [3:0] s;
		s = 4'h0;
		if (t[SLRXC_TRIM_SIGN]) begin // [R1]
			s = {1'b0, cal} - {1'b0, t[2:0]};
			slrxc_trim = s[3] ? 3'h0 : s[2:0];
		end else begin
			s = {1'b0, cal} + {1'b0, t[2:0]};
			slrxc_trim = s[3] ? 3'h7 : s[2:0];
		end
	endfunction

	// adjusted termination codes, one register per lane
	logic [2:0] term5_q, term5_d, term6_q, term6_d, term7_q, term7_d;

	// each lane uses only its own trim, so lanes never disturb each other
	always_comb begin
		term5_d = slrxc_trim(cal_term_lane5, trim5_q); // [R2]
		term6_d = slrxc_trim(cal_term_lane6, trim6_q); // [R2]
		term7_d = slrxc_trim(cal_term_lane7, trim7_q); // [R2]
	end

	// register the adjusted codes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			term5_q <= SLRXC_TERM_RST;
			term6_q <= SLRXC_TERM_RST;
			term7_q <= SLRXC_TERM_RST;
		end else begin
			term5_q <= term5_d;
			term6_q <= term6_d;
			term7_q <= term7_d;
		end
	end

	// control fields straight from flip-flops
	assign link_enable = link_en_q; // [R4]
	assign checksum_octets = cksum_q; // [R3]
	assign fixed_multiframe_delay = fixdly_q; // [R6]
	assign buffer_release_position = rel_q; // [R7]
	assign logical_lane0_source = lane0_q;
	assign logical_lane1_source = lane1_q; // [R10]

	// termination outputs straight from flip-flops
	assign term_lane5 = term5_q; // [R2]
	assign term_lane6 = term6_q; // [R2]
	assign term_lane7 = term7_q; // [R2]

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == SLRXC_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest)
		else $error("waitrequest did not drop one cycle after request");
	a_latency_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
		(st_q == SLRXC_IDLE && avs_read && idx == SLRXC_IDX_LAT)
		|=> avs_readdata == {27'h0, $past(measured_latency)})
		else $error("latency read mismatch");
	a_ctrl_resv_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
		(st_q == SLRXC_IDLE && avs_read && idx == SLRXC_IDX_CTRL)
		|=> avs_readdata[5:1] == 5'h00 && avs_readdata[31:7] == 25'h0)
		else $error("reserved control bits not zero");
	a_trim_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
		(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_TRIM6)
		|=> trim6_q == $past(avs_writedata[3:0]))
		else $error("trim write lost");
	a_trim_sub: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
		(trim5_q[3] && cal_term_lane5 >= {1'b0, trim5_q[2:1]} && $stable(trim5_q)
		&& {1'b0, cal_term_lane5} >= {1'b0, trim5_q[2:0]})
		|=> term_lane5 == $past(cal_term_lane5) - $past(trim5_q[2:0]))
		else $error("lane 5 subtraction wrong");
	a_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
		(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_CTRL)
		|=> link_enable == $past(avs_writedata[0]) ##1 link_enable == $past(link_enable))
		else $error("link enable write wrong");
	a_cksum_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
		(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_CTRL)
		|=> checksum_octets == $past(avs_writedata[6]))
		else $error("checksum mode write wrong");
	a_delay_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
		(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_FIXDLY)
		|=> fixed_multiframe_delay == $past(avs_writedata[4:0]))
		else $error("fixed delay write wrong");
	a_release_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
		(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_REL)
		|=> buffer_release_position == $past(avs_writedata[4:0]))
		else $error("release position write wrong");
	a_lane1_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R9]
		(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_XBAR01)
		|=> logical_lane1_source == $past(avs_writedata[5:3]))
		else $error("lane 1 source write wrong");

	// unmapped and reserved bits
	a_unmapped_resp: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
		(st_q == SLRXC_IDLE && (avs_read || avs_write) && !hit)
		|=> avs_response == 2'b11 && avs_readdata == 32'h00000000)
		else $error("unmapped access not refused");
	a_read_high_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
		(st_q == SLRXC_IDLE && avs_read)
		|=> avs_readdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_xbar_resv_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
		(st_q == SLRXC_IDLE && avs_read && idx == SLRXC_IDX_XBAR01)
		|=> avs_readdata[7:6] == 2'h0)
		else $error("reserved crossbar bits not zero");
	a_trim_resv_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
		(st_q == SLRXC_IDLE && avs_read && idx == SLRXC_IDX_TRIM7)
		|=> avs_readdata[7:4] == 4'h0)
		else $error("reserved trim bits not zero");

	// trim arithmetic on the other lanes
	a_trim_add: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
		(!trim6_q[3] && ({1'b0, cal_term_lane6} + {1'b0, trim6_q[2:0]}) <= 4'h7)
		|=> term_lane6 == $past(cal_term_lane6) + $past(trim6_q[2:0]))
		else $error("lane 6 addition wrong");
	a_trim_sat_hi: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
		(!trim7_q[3] && ({1'b0, cal_term_lane7} + {1'b0, trim7_q[2:0]}) > 4'h7)
		|=> term_lane7 == 3'h7)
		else $error("lane 7 upper saturation wrong");
	a_trim_sat_lo: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
		(trim7_q[3] && cal_term_lane7 < trim7_q[2:0])
		|=> term_lane7 == 3'h0)
		else $error("lane 7 lower saturation wrong");

	// fields change only on their own landed write
	a_no_lane_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
		(st_q == SLRXC_IDLE && avs_write && !avs_byteenable[0])
		|=> $stable(fixed_multiframe_delay) && $stable(buffer_release_position))
		else $error("write without low byte enable landed");
	a_lane1_stable: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R9]
		!(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_XBAR01)
		|=> $stable(logical_lane1_source))
		else $error("lane 1 source changed without write");
	a_enable_stable: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
		!(st_q == SLRXC_IDLE && wr_lo && idx == SLRXC_IDX_CTRL)
		|=> $stable(link_enable))
		else $error("link enable changed without write");
endmodule
`default_nettype wire

/* dv/slrxc_far.sv */
// far-side model: lane calibration codes and measured link latency
// assumes the bench sets both values; each reaches the slice one cycle later
`timescale 1ns/1ns
`default_nettype none
module slrxc_far (
	// clock
	input wire logic clk_sys,
	// bench settings
	input wire logic [4:0] lat_set,
	input wire logic [8:0] cal_set,
	// towards the slice
	output var logic [4:0] measured_latency,
	output var logic [2:0] cal_term_lane5,
	output var logic [2:0] cal_term_lane6,
	output var logic [2:0] cal_term_lane7
);
	// register the settings as a measuring front end would
	always_ff @(posedge clk_sys) begin
		measured_latency <= lat_set;
		{cal_term_lane7, cal_term_lane6, cal_term_lane5} <= cal_set;
	end
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the link receive register slice
// assumes slrxc_pkg and the far-side model slrxc_far
`timescale 1ns/1ns
`default_nettype none
module tb import slrxc_pkg::*; ;
	logic clk_sys = 0, nrst = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [11:0] avs_address = 12'h000;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [1:0] avs_response;
	logic [3:0] avs_byteenable = 4'hf;
	logic [4:0] lat_set = 5'h13, mlat, fdly, relp;
	logic [8:0] cal_set = 9'h000;
	logic [2:0] c5, c6, c7, t5, t6, t7, src0, src1;
	logic len, cko;
	logic [33:0] expq[$];
	int err_count = 0, num_checks = 0, cycles = 0;
	logic [9:0] idx_t[8] = '{SLRXC_IDX_TRIM5, SLRXC_IDX_TRIM6, SLRXC_IDX_TRIM7, SLRXC_IDX_LAT,
		SLRXC_IDX_FIXDLY, SLRXC_IDX_REL, SLRXC_IDX_XBAR01, SLRXC_IDX_CTRL};
	logic [7:0] rst_t[8] = '{8'h00, 8'h00, 8'h00, 8'h13, 8'h00, 8'h1f, 8'h08, 8'h00};
	logic [7:0] msk_t[8] = '{8'h0f, 8'h0f, 8'h0f, 8'h00, 8'h1f, 8'h1f, 8'h3f, 8'h41};
	logic [7:0] wv;
	logic [11:0] tr;
	//////////////////////////////////////////////////////////////////////
	always #2 clk_sys = ~clk_sys;
	slrxc_far i_far (.clk_sys(clk_sys), .lat_set(lat_set), .cal_set(cal_set),
		.measured_latency(mlat), .cal_term_lane5(c5), .cal_term_lane6(c6), .cal_term_lane7(c7));
	slrxc_regs i_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .cal_term_lane5(c5), .cal_term_lane6(c6),
		.cal_term_lane7(c7), .term_lane5(t5), .term_lane6(t6), .term_lane7(t7),
		.measured_latency(mlat), .link_enable(len), .checksum_octets(cko),
		.fixed_multiframe_delay(fdly), .buffer_release_position(relp),
		.logical_lane0_source(src0), .logical_lane1_source(src1));
	//////////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [33:0] seen, logic [33:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// one avalon transfer, held until waitrequest is sampled low
	task automatic xfer(logic w, logic [9:0] idx, logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		@(posedge clk_sys iff !avs_waitrequest);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(logic [9:0] idx, logic [7:0] e, logic [1:0] r = 2'b00);
		expq.push_back({r, 24'h0, e});
		xfer(1'b0, idx, 8'h00);
	endtask
	function automatic logic [2:0] sat(logic [2:0] c, logic [3:0] t);
		int v;
		v = t[3] ? int'(c) - int'(t[2:0]) : int'(c) + int'(t[2:0]);
		return v < 0 ? 3'h0 : (v > 7 ? 3'h7 : 3'(v));
	endfunction
	//////////////////////////////////////////////////////////////////////
	// read monitor: oldest note against the answer
	always @(posedge clk_sys) if (avs_read && !avs_waitrequest)
		check("readback", {avs_response, avs_readdata}, expq.pop_front());
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end
	// main sequence
	initial begin
		void'($urandom(32'hf14b));
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) rd(idx_t[i], rst_t[i]);
		// program every field, link enable last
		for (int i = 0; i < 8; i++) begin
			wv = (idx_t[i] == SLRXC_IDX_REL) ? {3'h7, SLRXC_REL_MAX} : 8'hff;
			xfer(1'b1, idx_t[i], wv);
			rd(idx_t[i], (wv & msk_t[i]) | (i == 3 ? 8'h13 : 8'h00));
		end
		check("link", {len, cko, fdly, relp, src0}, {2'b11, 5'h1f, 5'h0a, 3'h7});
		xfer(1'b1, SLRXC_IDX_CTRL, 8'h01);
		@(posedge clk_sys);
		check("cksum", {len, cko}, 2'b10);
		// a write without its low byte enable must not land
		avs_byteenable <= 4'he;
		xfer(1'b1, SLRXC_IDX_FIXDLY, 8'h05);
		avs_byteenable <= 4'hf;
		rd(SLRXC_IDX_FIXDLY, 8'h1f);
		xfer(1'b1, 10'h301, 8'hff);
		rd(10'h301, 8'h00, 2'b11);
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, SLRXC_IDX_XBAR01, {2'b00, 3'(c), 3'h0});
			@(posedge clk_sys);
			check("lane1", {src1, src0}, {3'(c), 3'h0});
		end
		repeat (8) begin
			cal_set <= 9'($urandom);
			tr = 12'($urandom);
			xfer(1'b1, SLRXC_IDX_TRIM5, {4'h0, tr[3:0]});
			xfer(1'b1, SLRXC_IDX_TRIM6, {4'h0, tr[7:4]});
			xfer(1'b1, SLRXC_IDX_TRIM7, {4'h0, tr[11:8]});
			repeat (3) @(posedge clk_sys);
			check("term", {t7, t6, t5}, {sat(cal_set[8:6], tr[11:8]),
				sat(cal_set[5:3], tr[7:4]), sat(cal_set[2:0], tr[3:0])});
		end
		// second reset in mid-run: every field back to its reset value
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) rd(idx_t[i], rst_t[i]);
		complete_run();
	end
endmodule
`default_nettype wire
